/* File: verilog/cvc_top.sv */
// Comparator and voltage reference control block with APB registers
`timescale 1ns/10ps
`default_nettype none
`include "cvc_params.svh"

// Summary of operation
// - Second result bit 7, inverted when selected
// - First result bit 6, inverted when selected
// - Bit 5 inverts second comparator output
// - Bit 4 inverts first comparator output
// - Mode 110 applies input switch to negatives
// - Writable 3-bit mode field selects configuration
// - Results drive pins and readable register bits
// - Inputs chosen among pins 0-5, ladder
// - Reset clears reference enable bit 7
// - Reset clears reference pin drive bit 6
// - Reset clears range select bit 5
// - Reset clears reference value select bits
// - Sleep wake leaves reference register unchanged

module cvc_top
  import cvc_pkg::*;
(
  input wire logic clock_i,
  input wire logic arst_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [`CVC_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Raw analog comparator decisions, asynchronous
  input wire logic cmp_a_raw_i,
  input wire logic cmp_b_raw_i,
  // Comparator enables and input multiplexer selects
  output logic cmp_a_en_o,
  output logic cmp_b_en_o,
  output logic [2:0] cmp_a_pos_sel_o,
  output logic [2:0] cmp_a_neg_sel_o,
  output logic [2:0] cmp_b_pos_sel_o,
  output logic [2:0] cmp_b_neg_sel_o,
  // Pin-level comparator outputs
  output logic cmp_a_out_o,
  output logic cmp_b_out_o,
  // Reference ladder controls
  output logic vref_on_o,
  output logic vref_pin_drive_o,
  output logic vref_range_sel_o,
  output logic [3:0] vref_value_o
);

  // Writable comparator fields
  logic cmp_b_invert_r;
  logic cmp_a_invert_r;
  logic input_switch_sel_r;
  logic [2:0] cmp_config_field_r;

  // Result bits, pin outputs and routing
  logic cmp_a_result_r;
  logic cmp_b_result_r;
  logic cmp_a_result_nxt;
  logic cmp_b_result_nxt;
  cvc_route_t route_a_r;
  cvc_route_t route_b_r;
  cvc_route_t route_a_nxt;
  cvc_route_t route_b_nxt;

  // Reference control fields
  logic vref_on_r;
  logic vref_pin_drive_r;
  logic vref_range_sel_r;
  logic [3:0] vref_value_r;

  // Synchronised analog decisions
  logic [`CVC_SYNC_W-1:0] raw_sync;
  logic cmp_a_level;
  logic cmp_b_level;

  // Register bus decode
  logic wr_cmp;
  logic wr_vref;
  logic [7:0] cmp_ctrl_rd;
  logic [7:0] vref_ctrl_rd;
  logic [7:0] cmp_stat_rd;

  cvc_regbus_if rb ();

  // Routing decode for one comparator from mode, switch and position
  function automatic cvc_route_t cvc_route(
    input logic [2:0] mode,
    input logic sw,
    input logic second
  );
    cvc_route_t r;
    r.en = 1'b1;
    r.pos = second ? cvc_src_pin2 : cvc_src_pin3;
    r.neg = second ? cvc_src_pin1 : cvc_src_pin0;
    unique case (mode)
      3'h0: begin
        // Both comparators held off
        r.en = 1'b0;
        r.pos = cvc_src_none;
        r.neg = cvc_src_none;
      end
      3'h1: begin
        // First comparator alone on its own pins
        r.en = !second;
      end
      3'h2: begin
        // Two independent comparators on pins 0-3
        r.en = 1'b1;
      end
      3'h3: begin
        // Both compare against the ladder
        r.pos = cvc_src_ladder;
      end
      3'h4: begin
        // Common positive reference on pin 2
        r.pos = cvc_src_pin2;
      end
      3'h5: begin
        // Second comparator alone against pins 4 and 5
        r.en = second;
        r.pos = cvc_src_pin5;
        r.neg = cvc_src_pin4;
      end
      `CVC_CFG_SWITCHED: begin
        // Four inputs multiplexed against the ladder
        r.pos = cvc_src_ladder;
        if (sw) begin
          r.neg = second ? cvc_src_pin2 : cvc_src_pin3;
        end else begin
          r.neg = second ? cvc_src_pin1 : cvc_src_pin0;
        end
      end
      3'h7: begin
        // Comparators off, the reset state
        r.en = 1'b0;
        r.pos = cvc_src_none;
        r.neg = cvc_src_none;
      end
    endcase
    return r;
  endfunction : cvc_route

  // APB front end
  cvc_apb_slave u_apb (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .rb(rb.bus)
  );

  // Bring the analog decisions into the clock domain
  cvc_sync u_sync (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .async_i({cmp_b_raw_i, cmp_a_raw_i}),
    .sync_o(raw_sync)
  );

  assign cmp_a_level = raw_sync[0];
  assign cmp_b_level = raw_sync[1];

  // Address decode of the writable registers
  assign wr_cmp = rb.wr && (rb.addr == `CVC_OFF_CMP_CTRL);
  assign wr_vref = rb.wr && (rb.addr == `CVC_OFF_VREF_CTRL);

  // Comparator control writable fields; result bits ignore writes
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmp_b_invert_r <= 1'b0;
      cmp_a_invert_r <= 1'b0;
      input_switch_sel_r <= 1'b0;
      cmp_config_field_r <= `CVC_CFG_RESET;
    end else if (wr_cmp) begin
      cmp_b_invert_r <= rb.wdata[`CVC_CMP_B_INVERT_BIT];
      cmp_a_invert_r <= rb.wdata[`CVC_CMP_A_INVERT_BIT];
      input_switch_sel_r <= rb.wdata[`CVC_INPUT_SWITCH_BIT];
      cmp_config_field_r <= rb.wdata[`CVC_CFG_MSB:`CVC_CFG_LSB];
    end
  end

  // Reference control; only the block reset clears it, sleep has no path
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      vref_on_r <= 1'b0;
      vref_pin_drive_r <= 1'b0;
      vref_range_sel_r <= 1'b0;
      vref_value_r <= 4'h0;
    end else if (wr_vref) begin
      vref_on_r <= rb.wdata[`CVC_VREF_ON_BIT];
      vref_pin_drive_r <= rb.wdata[`CVC_VREF_PIN_BIT];
      vref_range_sel_r <= rb.wdata[`CVC_VREF_RANGE_BIT];
      vref_value_r <= rb.wdata[`CVC_VREF_VAL_MSB:`CVC_VREF_VAL_LSB];
    end
  end

  // Routing of both comparators; switch only matters in mode 110
  always_comb begin
    route_a_nxt = cvc_route(cmp_config_field_r, input_switch_sel_r, 1'b0);
    route_b_nxt = cvc_route(cmp_config_field_r, input_switch_sel_r, 1'b1);
  end

  // Registered multiplexer selects and enables
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      route_a_r <= '{en: 1'b0, pos: cvc_src_none, neg: cvc_src_none};
      route_b_r <= '{en: 1'b0, pos: cvc_src_none, neg: cvc_src_none};
    end else begin
      route_a_r <= route_a_nxt;
      route_b_r <= route_b_nxt;
    end
  end

  // Polarity per comparator; a disabled comparator reads low
  always_comb begin
    cmp_a_result_nxt = route_a_r.en && (cmp_a_level ^ cmp_a_invert_r);
    cmp_b_result_nxt = route_b_r.en && (cmp_b_level ^ cmp_b_invert_r);
  end

  // Result flops feed both the pins and the register readback
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmp_a_result_r <= 1'b0;
      cmp_b_result_r <= 1'b0;
    end else begin
      cmp_a_result_r <= cmp_a_result_nxt;
      cmp_b_result_r <= cmp_b_result_nxt;
    end
  end

  // Readback images of each register
  always_comb begin
    cmp_ctrl_rd = 8'h00;
    cmp_ctrl_rd[`CVC_CMP_B_RESULT_BIT] = cmp_b_result_r;
    cmp_ctrl_rd[`CVC_CMP_A_RESULT_BIT] = cmp_a_result_r;
    cmp_ctrl_rd[`CVC_CMP_B_INVERT_BIT] = cmp_b_invert_r;
    cmp_ctrl_rd[`CVC_CMP_A_INVERT_BIT] = cmp_a_invert_r;
    cmp_ctrl_rd[`CVC_INPUT_SWITCH_BIT] = input_switch_sel_r;
    cmp_ctrl_rd[`CVC_CFG_MSB:`CVC_CFG_LSB] = cmp_config_field_r;
    vref_ctrl_rd = `CVC_VREF_RESET;
    vref_ctrl_rd[`CVC_VREF_ON_BIT] = vref_on_r;
    vref_ctrl_rd[`CVC_VREF_PIN_BIT] = vref_pin_drive_r;
    vref_ctrl_rd[`CVC_VREF_RANGE_BIT] = vref_range_sel_r;
    vref_ctrl_rd[`CVC_VREF_VAL_MSB:`CVC_VREF_VAL_LSB] = vref_value_r;
    cmp_stat_rd = 8'h00;
    cmp_stat_rd[`CVC_STAT_A_EN_BIT] = route_a_r.en;
    cmp_stat_rd[`CVC_STAT_B_EN_BIT] = route_b_r.en;
    cmp_stat_rd[`CVC_STAT_A_RAW_BIT] = cmp_a_level;
    cmp_stat_rd[`CVC_STAT_B_RAW_BIT] = cmp_b_level;
  end

  // Read mux with decode hit for the slave's error answer
  always_comb begin
    rb.rdata = 8'h00;
    rb.hit = 1'b1;
    unique case (rb.addr)
      `CVC_OFF_CMP_CTRL: begin
        rb.rdata = cmp_ctrl_rd;
      end
      `CVC_OFF_VREF_CTRL: begin
        rb.rdata = vref_ctrl_rd;
      end
      `CVC_OFF_CMP_STAT: begin
        rb.rdata = cmp_stat_rd;
      end
      default: begin
        rb.hit = 1'b0;
      end
    endcase
  end

  // Pin-level outputs, all from flops
  assign cmp_a_out_o = cmp_a_result_r;
  assign cmp_b_out_o = cmp_b_result_r;
  assign cmp_a_en_o = route_a_r.en;
  assign cmp_b_en_o = route_b_r.en;
  assign cmp_a_pos_sel_o = route_a_r.pos;
  assign cmp_a_neg_sel_o = route_a_r.neg;
  assign cmp_b_pos_sel_o = route_b_r.pos;
  assign cmp_b_neg_sel_o = route_b_r.neg;
  assign vref_on_o = vref_on_r;
  assign vref_pin_drive_o = vref_pin_drive_r;
  assign vref_range_sel_o = vref_range_sel_r;
  assign vref_value_o = vref_value_r;

endmodule : cvc_top

`default_nettype wire

/* File: shared/cvc_params.svh */
// Offsets, field positions, reset values and widths of the comparator control block
`ifndef CVC_PARAMS_SVH
`define CVC_PARAMS_SVH

// APB address width and register byte offsets
`define CVC_ADDR_W 8
`define CVC_OFF_CMP_CTRL 8'h00
`define CVC_OFF_VREF_CTRL 8'h04
`define CVC_OFF_CMP_STAT 8'h08

// Comparator control fields
`define CVC_CMP_B_RESULT_BIT 7
`define CVC_CMP_A_RESULT_BIT 6
`define CVC_CMP_B_INVERT_BIT 5
`define CVC_CMP_A_INVERT_BIT 4
`define CVC_INPUT_SWITCH_BIT 3
`define CVC_CFG_MSB 2
`define CVC_CFG_LSB 0
`define CVC_CFG_RESET 3'h7
`define CVC_CFG_SWITCHED 3'h6

// Reference control fields
`define CVC_VREF_ON_BIT 7
`define CVC_VREF_PIN_BIT 6
`define CVC_VREF_RANGE_BIT 5
`define CVC_VREF_VAL_MSB 3
`define CVC_VREF_VAL_LSB 0
`define CVC_VREF_RESET 8'h00

// Status fields
`define CVC_STAT_A_EN_BIT 0
`define CVC_STAT_B_EN_BIT 1
`define CVC_STAT_A_RAW_BIT 2
`define CVC_STAT_B_RAW_BIT 3

// Synchroniser lane count; the depth of three stages is fixed in cvc_sync
`define CVC_SYNC_W 2

`endif

/* File: shared/cvc_pkg.sv */
// Types shared by the comparator control block
package cvc_pkg;

  // Analog source feeding one comparator input
  typedef enum logic [2:0] {
    cvc_src_pin0,
    cvc_src_pin1,
    cvc_src_pin2,
    cvc_src_pin3,
    cvc_src_pin4,
    cvc_src_pin5,
    cvc_src_ladder,
    cvc_src_none
  } cvc_src_t;

  // Routing of one comparator
  typedef struct packed {
    logic en;
    cvc_src_t pos;
    cvc_src_t neg;
  } cvc_route_t;

endpackage : cvc_pkg

/* File: shared/cvc_regbus_if.sv */
// Internal register access bus between the APB slave and the register file
`timescale 1ns/10ps
`default_nettype none
`include "cvc_params.svh"

interface cvc_regbus_if;
  logic wr;
  logic [`CVC_ADDR_W-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic hit;

  modport bus (output wr, output addr, output wdata, input rdata, input hit);
  modport regs (input wr, input addr, input wdata, output rdata, output hit);
endinterface : cvc_regbus_if

`default_nettype wire

/* File: verilog/cvc_sync.sv */
// Three-stage synchroniser for the comparator result levels
`timescale 1ns/10ps
`default_nettype none
`include "cvc_params.svh"

module cvc_sync (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic [`CVC_SYNC_W-1:0] async_i,
  output logic [`CVC_SYNC_W-1:0] sync_o
);

  logic [`CVC_SYNC_W-1:0] meta_r;
  logic [`CVC_SYNC_W-1:0] stage2_r;
  logic [`CVC_SYNC_W-1:0] stage3_r;
  logic [`CVC_SYNC_W-1:0] level_r;

  genvar g;
  generate
    for (g = 0; g < `CVC_SYNC_W; g++) begin : g_lane
      // Shift chain; first stage feeds only the second
      always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          meta_r[g] <= 1'b0;
          stage2_r[g] <= 1'b0;
          stage3_r[g] <= 1'b0;
        end else begin
          meta_r[g] <= async_i[g];
          stage2_r[g] <= meta_r[g];
          stage3_r[g] <= stage2_r[g];
        end
      end

      // Accept a new level once the last two stages agree
      always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          level_r[g] <= 1'b0;
        end else if (stage2_r[g] == stage3_r[g]) begin
          level_r[g] <= stage3_r[g];
        end
      end
    end
  endgenerate

  assign sync_o = level_r;

endmodule : cvc_sync

`default_nettype wire

/* File: verilog/cvc_apb_slave.sv */
// APB slave front end that drives the internal register bus
`timescale 1ns/10ps
`default_nettype none
`include "cvc_params.svh"

module cvc_apb_slave (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [`CVC_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  cvc_regbus_if.bus rb
);

  logic [7:0] rdata_r;
  logic err_r;
  logic setup;

  assign setup = psel_i && !penable_i;

  // Address and data go straight to the register file
  assign rb.addr = paddr_i;
  assign rb.wdata = pwdata_i[7:0];
  assign rb.wr = psel_i && penable_i && pwrite_i && rb.hit;

  // Capture read data and decode result in the setup cycle
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_r <= 8'h00;
      err_r <= 1'b0;
    end else if (setup) begin
      rdata_r <= pwrite_i ? 8'h00 : rb.rdata;
      err_r <= !rb.hit;
    end
  end

  // Zero wait states; upper data bits read as zero
  assign pready_o = psel_i && penable_i;
  assign prdata_o = {24'h000000, rdata_r};
  assign pslverr_o = psel_i && penable_i && err_r;

endmodule : cvc_apb_slave

`default_nettype wire

/* File: testbench/cvc_assertions.sv */
// Port-level checker for the comparator and reference control block
`timescale 1ns/10ps
`default_nettype none

module cvc_assertions (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic cmp_a_en_o,
  input wire logic cmp_b_en_o,
  input wire logic [2:0] cmp_a_pos_sel_o,
  input wire logic [2:0] cmp_a_neg_sel_o,
  input wire logic [2:0] cmp_b_pos_sel_o,
  input wire logic [2:0] cmp_b_neg_sel_o,
  input wire logic cmp_a_out_o,
  input wire logic cmp_b_out_o,
  input wire logic vref_on_o,
  input wire logic vref_pin_drive_o,
  input wire logic vref_range_sel_o,
  input wire logic [3:0] vref_value_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  // Access-phase decodes
  logic acc;
  logic wr_cmp;
  logic [6:0] vref_all;
  assign acc = psel_i && penable_i;
  assign wr_cmp = acc && pwrite_i && paddr_i == 8'h00;
  assign vref_all = {vref_on_o, vref_pin_drive_o, vref_range_sel_o, vref_value_o};

  access_ready_a: assert property (acc |-> pready_o)
    else $error("pready low in access phase");
  read_upper_a: assert property (acc && !pwrite_i |-> prdata_o[31:8] == 24'h000000)
    else $error("upper read data not zero");
  unmapped_err_a: assert property (acc && !(paddr_i inside {8'h00, 8'h04, 8'h08}) |-> pslverr_o)
    else $error("unmapped access without error");
  vref_reset_a: assert property (
    !$past(arst_n_i) |-> vref_all == 7'h00) else $error("reference not cleared by reset");
  vref_hold_a: assert property (
    !(acc && pwrite_i && paddr_i == 8'h04) |=> $stable(vref_all))
    else $error("reference changed without a write");
  result_read_a: assert property (
    acc && !pwrite_i && paddr_i == 8'h00 |-> prdata_o[7:6] == $past({cmp_b_out_o, cmp_a_out_o}))
    else $error("result bits differ from output pins");
  switch_route_a: assert property (
    wr_cmp && pwdata_i[2:0] == 3'h6 |-> ##2 cmp_a_pos_sel_o == 3'h6
    && cmp_a_neg_sel_o == ($past(pwdata_i[3], 2) ? 3'h3 : 3'h0)
    && cmp_b_neg_sel_o == ($past(pwdata_i[3], 2) ? 3'h2 : 3'h1))
    else $error("switched mode routing wrong");
  switch_ignored_a: assert property (
    wr_cmp && pwdata_i[2:0] == 3'h2 |-> ##2
    {cmp_a_pos_sel_o, cmp_a_neg_sel_o, cmp_b_pos_sel_o, cmp_b_neg_sel_o} == 12'h611)
    else $error("two-comparator routing wrong");
  mode_off_a: assert property (
    wr_cmp && pwdata_i[2:0] inside {3'h0, 3'h7} |-> ##2 !cmp_a_en_o && !cmp_b_en_o)
    else $error("comparators on in off mode");
  b_only_a: assert property (
    wr_cmp && pwdata_i[2:0] == 3'h5 |-> ##2 !cmp_a_en_o && cmp_b_en_o)
    else $error("single comparator mode wrong");

  // Main scenarios reached
  cover property (wr_cmp && pwdata_i[2:0] == 3'h6 && pwdata_i[3]);
  cover property (acc && pslverr_o);
  cover property (acc && !pwrite_i && paddr_i == 8'h08);
  cover property (acc && !pwrite_i && paddr_i == 8'h00 && prdata_o[7]);
endmodule : cvc_assertions

`default_nettype wire

/* File: testbench/cvc_analog_model.sv */
// Behavioural analog side: pin levels, reference ladder and two comparators
`timescale 1ns/10ps
`default_nettype none

module cvc_analog_model (
  input wire logic [23:0] pin_lvl_i,
  input wire logic vref_on_i,
  input wire logic [3:0] vref_value_i,
  input wire logic [2:0] a_pos_i,
  input wire logic [2:0] a_neg_i,
  input wire logic [2:0] b_pos_i,
  input wire logic [2:0] b_neg_i,
  output logic a_raw_o,
  output logic b_raw_o
);
  // Level of one source: six pins, ladder, nothing
  function automatic logic [3:0] lvl(input logic [2:0] s);
    if (s < 3'h6) begin
      return pin_lvl_i[s*4 +: 4];
    end
    return (s == 3'h6 && vref_on_i) ? vref_value_i : 4'h0;
  endfunction : lvl

  // Raw decisions, 1 when the positive input is higher
  always_comb begin
    a_raw_o = lvl(a_pos_i) > lvl(a_neg_i);
    b_raw_o = lvl(b_pos_i) > lvl(b_neg_i);
  end
endmodule : cvc_analog_model

`default_nettype wire

/* File: testbench/cvc_top_tb.sv */
// Self-checking bench for the comparator and reference control block
`timescale 1ns/10ps
`default_nettype none

module cvc_top_tb;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, a_raw, b_raw, a_en, b_en, a_out, b_out;
  logic [2:0] a_pos, a_neg, b_pos, b_neg;
  logic v_on, v_pin, v_rng;
  logic [3:0] v_val;
  logic [23:0] pin_lvl = 24'h0;
  logic [7:0] rd;
  logic err;
  logic [13:0] mt [8];
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;

  cvc_top u_dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .cmp_a_raw_i(a_raw),
    .cmp_b_raw_i(b_raw), .cmp_a_en_o(a_en), .cmp_b_en_o(b_en), .cmp_a_pos_sel_o(a_pos),
    .cmp_a_neg_sel_o(a_neg), .cmp_b_pos_sel_o(b_pos), .cmp_b_neg_sel_o(b_neg),
    .cmp_a_out_o(a_out), .cmp_b_out_o(b_out), .vref_on_o(v_on), .vref_pin_drive_o(v_pin),
    .vref_range_sel_o(v_rng), .vref_value_o(v_val));

  cvc_analog_model u_ana (.pin_lvl_i(pin_lvl), .vref_on_i(v_on), .vref_value_i(v_val),
    .a_pos_i(a_pos), .a_neg_i(a_neg), .b_pos_i(b_pos), .b_neg_i(b_neg),
    .a_raw_o(a_raw), .b_raw_o(b_raw));

  // Clock at 4 ns period
  initial begin
    forever #2 clock_i = ~clock_i;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer, released after the edge that sees pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h0, d};
    @(posedge clock_i);
    penable_i <= 1'b1;
    do @(posedge clock_i); while (pready_o !== 1'b1);
    rd = prdata_o[7:0];
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clock_i);
  endtask : apb

  task automatic reset_values;
    apb(1'b0, 8'h00, 8'h00);
    check(rd, 8'h07);
    apb(1'b0, 8'h04, 8'h00);
    check(rd, 8'h00);
    check({1'b0, v_on, v_pin, v_rng, v_val}, 8'h00);
  endtask : reset_values

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  // Hang guard
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      stop_test();
    end
  end

  initial begin
    // Mode table: enables {b,a}, then a pos/neg, b pos/neg, switch bit set
    mt = '{{2'b00, 12'o0000}, {2'b01, 12'o3000}, {2'b11, 12'o3021}, {2'b11, 12'o6061},
      {2'b11, 12'o2021}, {2'b10, 12'o0054}, {2'b11, 12'o6362}, {2'b00, 12'o0000}};
    repeat (6) @(posedge clock_i);
    arst_n_i <= 1'b1;
    @(posedge clock_i);
    reset_values();
    apb(1'b0, 8'h0c, 8'h00);
    check({7'h0, err}, 8'h01);
    apb(1'b1, 8'h0c, 8'hff);
    apb(1'b0, 8'h04, 8'h00);
    check(rd, 8'h00);
    $display("reset and decode test done");
    for (int m = 0; m < 8; m++) begin
      apb(1'b1, 8'h00, {5'b00001, m[2:0]});
      apb(1'b0, 8'h00, 8'h00);
      check(rd, {5'b00001, m[2:0]});
      check({6'h0, b_en, a_en}, {6'h0, mt[m][13:12]});
      if (mt[m][12]) check({2'b00, a_pos, a_neg}, {2'b00, mt[m][11:6]});
      if (mt[m][13]) check({2'b00, b_pos, b_neg}, {2'b00, mt[m][5:0]});
    end
    $display("mode table test done");
    pin_lvl <= 24'h00c2c2;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'h00, {2'b11, i[1:0], 4'h2});
      repeat (8) @(posedge clock_i);
      apb(1'b0, 8'h00, 8'h00);
      check(rd, {i[1], ~i[0], i[1:0], 4'h2});
      check({6'h0, b_out, a_out}, {6'h0, i[1], ~i[0]});
    end
    $display("result polarity test done");
    apb(1'b1, 8'h04, 8'hef);
    apb(1'b0, 8'h04, 8'h00);
    check(rd, 8'hef);
    check({1'b0, v_on, v_pin, v_rng, v_val}, 8'h7f);
    apb(1'b1, 8'h04, 8'h88);
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, 8'h00, {4'h0, s[0], 3'h6});
      repeat (8) @(posedge clock_i);
      apb(1'b0, 8'h00, 8'h00);
      check(rd, {s[0], ~s[0], 2'b00, s[0], 3'h6});
      apb(1'b0, 8'h08, 8'h00);
      check(rd, {4'h0, s[0], ~s[0], 2'b11});
    end
    $display("input switch test done");
    arst_n_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    arst_n_i <= 1'b1;
    @(posedge clock_i);
    reset_values();
    $display("mid-run reset test done");
    stop_test();
  end
endmodule : cvc_top_tb

bind cvc_top cvc_assertions u_chk (.clock_i(clock_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .cmp_a_en_o(cmp_a_en_o),
  .cmp_b_en_o(cmp_b_en_o), .cmp_a_pos_sel_o(cmp_a_pos_sel_o),
  .cmp_a_neg_sel_o(cmp_a_neg_sel_o), .cmp_b_pos_sel_o(cmp_b_pos_sel_o),
  .cmp_b_neg_sel_o(cmp_b_neg_sel_o), .cmp_a_out_o(cmp_a_out_o), .cmp_b_out_o(cmp_b_out_o),
  .vref_on_o(vref_on_o), .vref_pin_drive_o(vref_pin_drive_o),
  .vref_range_sel_o(vref_range_sel_o), .vref_value_o(vref_value_o));

`default_nettype wire
